// [bench/smr_checker_assertions.sv]
// Concurrent checks on the responder ports.
`timescale 1ns/10ps
`default_nettype none
module smr_checker (
	input wire sys_clk,
	input wire rstn,
	input wire reg_rd,
	input wire [31:0] reg_rdata_q,
	input wire msg_valid,
	input wire msg_value_err,
	input wire alarm_req,
	input wire stream_req,
	input wire tx_ready,
	input wire [7:0] tx_data_q,
	input wire tx_valid_q,
	input wire tx_last_q,
	input wire busy_q
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_stall;
		tx_valid_q && !tx_ready;
	endsequence
	sequence s_end;
		tx_valid_q && tx_last_q && tx_ready;
	endsequence
	sequence s_idle_err;
		msg_valid && msg_value_err && !busy_q && !tx_valid_q;
	endsequence
	a_char_held: assert property (s_stall |=> tx_valid_q &&
		$stable(tx_data_q) && $stable(tx_last_q))
		else $error("character changed before accept");
	a_last_valid: assert property (tx_last_q |-> tx_valid_q)
		else $error("last flag without valid");
	a_msg_end: assert property (s_end |=> !tx_valid_q)
		else $error("valid stays after last accept");
	a_busy_tx: assert property (tx_valid_q |-> busy_q)
		else $error("character sent while not busy");
	a_alarm_reply: assert property (alarm_req |->
		##[1:400] tx_valid_q)
		else $error("alarm request not answered");
	a_stream_reply: assert property (stream_req |->
		##[1:900] tx_valid_q)
		else $error("stream request not answered");
	a_report_first: assert property (s_idle_err |->
		##[1:3] tx_valid_q && tx_data_q == 8'h50)
		else $error("value report does not start promptly");
	a_read_zero: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
		else $error("read data outside its cycle");
	a_char_set: assert property (tx_valid_q |->
		tx_data_q inside {[8'h20:8'h5a]})
		else $error("character outside the message set");
endmodule
bind smr_top smr_checker smr_checker_i (.sys_clk(sys_clk), .rstn(rstn),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .msg_valid(msg_valid),
	.msg_value_err(msg_value_err), .alarm_req(alarm_req),
	.stream_req(stream_req), .tx_ready(tx_ready), .tx_data_q(tx_data_q),
	.tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .busy_q(busy_q));
`default_nettype wire

// [bench/smr_sink.sv]
// Upstream character sink that collects whole outgoing messages.
`timescale 1ns/10ps
`default_nettype none
// It only listens, so it never originates a request of its own.
module smr_sink (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] tx_data_q,
	input wire logic tx_valid_q,
	input wire logic tx_last_q,
	output logic tx_ready,
	output logic [207:0] msg_q,
	output logic [7:0] count_q
);
	logic [207:0] acc_q;
	logic [1:0] ph_q;
	// Refusing one cycle in four keeps the hold of a waiting character busy.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= '0;
			msg_q <= '0;
			count_q <= 8'h00;
			ph_q <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			tx_ready <= ph_q != 2'h2;
			if (tx_valid_q && tx_ready) begin
				acc_q <= tx_last_q ? '0 : {acc_q[199:0], tx_data_q};
				if (tx_last_q) begin
					msg_q <= {acc_q[199:0], tx_data_q};
					count_q <= count_q + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [bench/smr_top_tb.sv]
// Self-checking bench for the supervision message responder.
`timescale 1ns/10ps
`default_nettype none
`include "smr_map.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module smr_top_tb;
	logic sys_clk, rstn, reg_wr, reg_rd, msg_valid, msg_value_err;
	logic msg_seq_err, alarm_req, stream_req, sec_tick, st_valid;
	logic st_missing, tx_ready, tx_valid_q, tx_last_q, busy_q;
	logic [3:0] reg_addr, st_slot;
	logic [31:0] reg_wdata, reg_rdata_q;
	logic [55:0] msg_cmd;
	logic [23:0] msg_ext;
	logic [4:0] alarm_active, alarm_avail, fc_upper;
	logic [11:0] st_id;
	logic [2:0] st_type;
	logic [1:0] st_err;
	logic [7:0] fc_lower, tx_data_q, count_q;
	logic [207:0] msg_q;
	int n_errors = 0;
	int compares = 0;
	localparam logic [55:0] bad_cmd = 56'h5355_4243_4841_4e;
	smr_top smr_top_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .msg_valid(msg_valid), .msg_cmd(msg_cmd),
		.msg_ext(msg_ext), .msg_value_err(msg_value_err),
		.msg_seq_err(msg_seq_err), .alarm_req(alarm_req),
		.stream_req(stream_req), .alarm_active(alarm_active),
		.alarm_avail(alarm_avail), .sec_tick(sec_tick), .st_valid(st_valid),
		.st_slot(st_slot), .st_id(st_id), .st_type(st_type),
		.st_missing(st_missing), .st_err(st_err), .fc_upper(fc_upper),
		.fc_lower(fc_lower), .tx_ready(tx_ready), .tx_data_q(tx_data_q),
		.tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .busy_q(busy_q));
	smr_sink smr_sink_i (.sys_clk(sys_clk), .rstn(rstn), .tx_data_q(tx_data_q),
		.tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready),
		.msg_q(msg_q), .count_q(count_q));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("register", e, reg_rdata_q)
	endtask
	task automatic pulse(input int w);
		@(posedge sys_clk);
		msg_valid <= (w == 0);
		alarm_req <= (w == 1);
		sec_tick <= (w == 2);
		stream_req <= (w == 3);
		st_valid <= (w == 4);
		@(posedge sys_clk);
		{msg_valid, alarm_req, sec_tick, stream_req, st_valid} <= '0;
	endtask
	function automatic logic [207:0] alm_def(input logic [119:0] t);
		return {`SMR_CMD_ALARM, `SMR_CH_SP, `SMR_EXT_DEF, t};
	endfunction
	function automatic logic [207:0] str_def(input logic [119:0] t);
		return {`SMR_CMD_STREAM, `SMR_CH_SP, `SMR_EXT_DEF, t};
	endfunction
	// Bounded wait for the sink to finish a given number of messages.
	task automatic wait_msg(input logic [7:0] n, input logic [207:0] e);
		for (int i = 0; i < 2000 && count_q !== n; i++) @(posedge sys_clk);
		`CHK("message count", n, count_q)
		`CHK("message", e, msg_q)
	endtask
	task automatic t_regs;
		rd(4'h0, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		rd(4'hc, 32'h0000_0000);
	endtask
	task automatic t_report(input logic v, input logic [23:0] x);
		logic [7:0] k;
		k = count_q;
		msg_cmd <= bad_cmd;
		msg_ext <= `SMR_EXT_DEF;
		msg_value_err <= v;
		msg_seq_err <= !v;
		pulse(0);
		wait_msg(k + 8'h01, {`SMR_CMD_REPORT, `SMR_CH_SP, x, `SMR_CH_SP,
			bad_cmd, `SMR_CH_SP, `SMR_EXT_DEF});
	endtask
	task automatic t_alarm;
		logic [7:0] k;
		wr(4'h4, 32'h0023_5958);
		alarm_active <= 5'h11;
		alarm_avail <= 5'h15;
		repeat (3) @(posedge sys_clk);
		k = count_q;
		pulse(1);
		wait_msg(k + 8'h01, alm_def(" 1X0X1 23:59:58"));
		pulse(2);
		pulse(2);
		rd(4'h4, 32'h0000_0000);
	endtask
	task automatic t_unsol;
		logic [7:0] k;
		wr(4'h0, 32'h0000_0003);
		k = count_q;
		alarm_active <= 5'h00;
		alarm_avail <= 5'h1f;
		wait_msg(k + 8'h01, alm_def(" 00000 00:00:00"));
	endtask
	task automatic st(input int s, input logic [11:0] id, input logic [2:0] t,
		input logic m, input logic [1:0] er, input logic [4:0] u,
		input logic [7:0] l);
		st_slot <= s[3:0];
		st_id <= id;
		st_type <= t;
		st_missing <= m;
		st_err <= er;
		fc_upper <= u;
		fc_lower <= l;
		pulse(4);
	endtask
	task automatic t_stream;
		logic [7:0] k;
		wr(4'h0, 32'h0000_0000);
		st(0, 12'hfff, 3'h5, 1'b0, 2'h1, 5'h13, 8'hf9);
		st(1, 12'h000, 3'h7, 1'b0, 2'h2, 5'h00, 8'h00);
		st(2, 12'h0a3, 3'h3, 1'b1, 2'h3, 5'h07, 8'h64);
		st(3, 12'h5c7, 3'h2, 1'b0, 2'h0, 5'h0a, 8'h05);
		k = count_q;
		pulse(3);
		wait_msg(k + 8'h01, str_def(" FFF 5 F 19:249"));
		wait_msg(k + 8'h02, str_def(" 000 7 C 00:000"));
		wait_msg(k + 8'h03, str_def(" 0A3 0 I 07:100"));
		wait_msg(k + 8'h04, str_def(" 5C7 2 N 10:005"));
		wr(4'h0, 32'h0000_0002);
		k = count_q;
		st(0, 12'h123, 3'h1, 1'b0, 2'h2, 5'h00, 8'h01);
		wait_msg(k + 8'h01, str_def(" 123 1 C 00:001"));
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{rstn, reg_wr, reg_rd, msg_valid, msg_value_err, msg_seq_err} = '0;
		{alarm_req, stream_req, sec_tick, st_valid, st_missing} = '0;
		{reg_addr, st_slot, reg_wdata, msg_cmd, msg_ext, st_id} = '0;
		{alarm_active, alarm_avail, fc_upper, st_type, st_err, fc_lower} = '0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_report(1'b1, `SMR_EXT_VALUE);
		t_report(1'b0, `SMR_EXT_SEQ);
		t_alarm();
		t_unsol();
		t_stream();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [inc/smr_map.vh]
// Constants for the supervision message responder: offsets, fields, codes.
// What this block does
// - A bad field value in a message triggers a value-error report.
// - Value-error report echoes the 7-char command and 3-char extension.
// - An out-of-sequence message triggers a sequence-violation report.
// - Sequence report echoes the 7-char command and 3-char extension.
// - Each of five alarms is always active, inactive or not available.
// - Frame-format alarm goes active on frame format faults.
// - Stream-content alarm goes active on invalid stream payload.
// - Inconsistency alarm goes active when frames contradict the setup.
// - Physical-interface alarm goes active on link faults.
// - Equipment alarm goes active on hardware or software malfunction.
// - An alarm-status request is answered by an alarm definition.
// - An alarm definition may also be sent when the status changes.
// - Alarm word is five chars in fixed order, each '0', '1' or 'X'.
// - Alarm definition carries an 8-char HH:MM:SS time of status start.
// - A stream-error request is answered with stream-error definitions.
// - A stream-error definition may also be sent when a stream changes.
// - Stream identifier is three hexadecimal characters, 000 to FFF.
// - Stream type is one decimal char 0 to 7, and 0 for a missing stream.
// - Error type char is F, C, I or N.
// - Frame count is six chars UU:LLL, upper 00-19, lower 000-249.
`ifndef SMR_MAP_VH
`define SMR_MAP_VH
`define SMR_REG_CTRL 4'h0
`define SMR_REG_TIME 4'h4
`define SMR_REG_STATUS 4'h8
`define SMR_REG_PEND 4'hc
`define SMR_CTRL_ALM_EN 0
`define SMR_CTRL_STR_EN 1
`define SMR_CTRL_RESET 2'h0
`define SMR_TIME_RESET 24'h00_0000
`define SMR_CMD_REPORT 56'h5052_4552_524f_52
`define SMR_CMD_ALARM 56'h414c_4152_4d53_54
`define SMR_CMD_STREAM 56'h5354_4552_524f_52
`define SMR_EXT_VALUE 24'h53_454d
`define SMR_EXT_SEQ 24'h50_5254
`define SMR_EXT_DEF 24'h44_4546
`define SMR_CH_SP 8'h20
`define SMR_CH_COLON 8'h3a
`define SMR_CH_ZERO 8'h30
`define SMR_CH_ONE 8'h31
`define SMR_CH_NA 8'h58
`define SMR_CH_F 8'h46
`define SMR_CH_C 8'h43
`define SMR_CH_I 8'h49
`define SMR_CH_N 8'h4e
`define SMR_LEN_REPORT 5'h17
`define SMR_LEN_DEF 5'h1a
`define SMR_ERR_NONE 2'h0
`define SMR_ERR_FORMAT 2'h1
`define SMR_ERR_CONTENT 2'h2
`define SMR_ERR_INCONS 2'h3
`define SMR_SLOTS 16
`define SMR_ENTRY_W 30
`endif

// [src/smr_stream_table.v]
// Stream error table: one write port, registered read port.
`timescale 1ns/10ps
`default_nettype none
module smr_stream_table (
	input wire sys_clk,
	input wire wr_en,
	input wire [3:0] wr_addr,
	input wire [29:0] wr_data,
	input wire [3:0] rd_addr,
	output reg [29:0] rd_data_q
);
	reg [29:0] mem [0:15];

	// The table holds data only, so it needs no reset; valid bits live outside.
	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// [src/smr_top.v]
// Supervision message responder: reports, alarm status and stream errors.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "smr_map.vh"
module smr_top (
	input wire sys_clk,
	input wire rstn,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	input wire msg_valid,
	input wire [55:0] msg_cmd,
	input wire [23:0] msg_ext,
	input wire msg_value_err,
	input wire msg_seq_err,
	input wire alarm_req,
	input wire stream_req,
	input wire [4:0] alarm_active,
	input wire [4:0] alarm_avail,
	input wire sec_tick,
	input wire st_valid,
	input wire [3:0] st_slot,
	input wire [11:0] st_id,
	input wire [2:0] st_type,
	input wire st_missing,
	input wire [1:0] st_err,
	input wire [4:0] fc_upper,
	input wire [7:0] fc_lower,
	input wire tx_ready,
	output reg [7:0] tx_data_q,
	output reg tx_valid_q,
	output reg tx_last_q,
	output reg busy_q
);
	localparam ST_IDLE = 2'd0;
	localparam ST_FETCH = 2'd1;
	localparam ST_LOAD = 2'd2;
	localparam ST_SEND = 2'd3;

	reg [1:0] state_q;
	reg [1:0] ctrl_q;
	reg [23:0] tod_q;
	reg [23:0] tod_d;
	reg [23:0] stamp_q;
	reg [39:0] alm_prev_q;
	reg alm_pend_q;
	reg val_pend_q;
	reg seq_pend_q;
	reg [55:0] val_cmd_q;
	reg [23:0] val_ext_q;
	reg [55:0] seq_cmd_q;
	reg [23:0] seq_ext_q;
	reg [15:0] st_used_q;
	reg [15:0] st_pend_q;
	reg [3:0] rd_slot_q;
	reg [207:0] msg_q;
	reg [4:0] remain_q;
	wire [29:0] entry;
	wire [29:0] wr_entry;
	wire [2:0] type_eff;
	wire [23:0] up_dig;
	reg [39:0] alm_word;
	reg [15:0] pend_set;
	reg [15:0] pend_clr;
	integer i;

	function [7:0] hex_ch;
		input [3:0] n;
		begin
			if (n < 4'ha) begin
				hex_ch = `SMR_CH_ZERO + {4'h0, n};
			end else begin
				hex_ch = 8'h37 + {4'h0, n};
			end
		end
	endfunction

	function [23:0] dec3;
		input [7:0] v;
		reg [7:0] h;
		reg [7:0] t;
		reg [7:0] u;
		begin
			h = v / 8'd100;
			t = (v / 8'd10) % 8'd10;
			u = v % 8'd10;
			dec3 = {`SMR_CH_ZERO + h, `SMR_CH_ZERO + t, `SMR_CH_ZERO + u};
		end
	endfunction

	function [3:0] lowest;
		input [15:0] v;
		integer k;
		begin
			lowest = 4'h0;
			for (k = 15; k >= 0; k = k - 1) begin
				if (v[k]) begin
					lowest = k[3:0];
				end
			end
		end
	endfunction

	function [7:0] err_ch;
		input [1:0] e;
		begin
			case (e)
				`SMR_ERR_FORMAT: err_ch = `SMR_CH_F;
				`SMR_ERR_CONTENT: err_ch = `SMR_CH_C;
				`SMR_ERR_INCONS: err_ch = `SMR_CH_I;
				default: err_ch = `SMR_CH_N;
			endcase
		end
	endfunction

	// Alarm order is frame format, content, inconsistency, physical, equipment.
	// Bit 4 of the alarm inputs is the frame-format alarm.
	always @* begin
		alm_word = 40'h00_0000_0000;
		for (i = 0; i < 5; i = i + 1) begin
			if (!alarm_avail[4 - i]) begin
				alm_word[39 - 8 * i -: 8] = `SMR_CH_NA;
			end else if (alarm_active[4 - i]) begin
				alm_word[39 - 8 * i -: 8] = `SMR_CH_ONE;
			end else begin
				alm_word[39 - 8 * i -: 8] = `SMR_CH_ZERO;
			end
		end
	end

	// Time of day in BCD digits hh:mm:ss, advanced by the seconds tick.
	always @* begin
		tod_d = tod_q;
		if (sec_tick) begin
			tod_d[3:0] = tod_q[3:0] + 4'h1;
			if (tod_q[3:0] == 4'h9) begin
				tod_d[3:0] = 4'h0;
				tod_d[7:4] = tod_q[7:4] + 4'h1;
				if (tod_q[7:4] == 4'h5) begin
					tod_d[7:4] = 4'h0;
					tod_d[11:8] = tod_q[11:8] + 4'h1;
					if (tod_q[11:8] == 4'h9) begin
						tod_d[11:8] = 4'h0;
						tod_d[15:12] = tod_q[15:12] + 4'h1;
						if (tod_q[15:12] == 4'h5) begin
							tod_d[15:12] = 4'h0;
							tod_d[19:16] = tod_q[19:16] + 4'h1;
							if (tod_q[23:16] == 8'h23) begin
								tod_d[23:16] = 8'h00;
							end else if (tod_q[19:16] == 4'h9) begin
								tod_d[19:16] = 4'h0;
								tod_d[23:20] = tod_q[23:20] + 4'h1;
							end
						end
					end
				end
			end
		end
		if (reg_wr && reg_addr == `SMR_REG_TIME) begin
			tod_d = reg_wdata[23:0];
		end
	end

	assign type_eff = st_missing ? 3'h0 : st_type;
	assign wr_entry = {st_id, type_eff, st_err, fc_upper, fc_lower};
	// The upper frame count never exceeds two digits, so its hundreds is cut.
	assign up_dig = dec3({3'h0, entry[12:8]});

	smr_stream_table u_table (
		.sys_clk(sys_clk),
		.wr_en(st_valid),
		.wr_addr(st_slot),
		.wr_data(wr_entry),
		.rd_addr(rd_slot_q),
		.rd_data_q(entry)
	);

	// A stream request marks every filled slot; a change marks its own slot.
	always @* begin
		pend_set = 16'h0000;
		pend_clr = 16'h0000;
		if (stream_req) begin
			pend_set = st_used_q;
		end
		if (st_valid && ctrl_q[`SMR_CTRL_STR_EN]) begin
			pend_set[st_slot] = 1'b1;
		end
		if (state_q == ST_IDLE && !val_pend_q && !seq_pend_q && !alm_pend_q) begin
			if (st_pend_q != 16'h0000) begin
				pend_clr[lowest(st_pend_q)] = 1'b1;
			end
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tod_q <= `SMR_TIME_RESET;
			stamp_q <= `SMR_TIME_RESET;
			alm_prev_q <= 40'h00_0000_0000;
			ctrl_q <= `SMR_CTRL_RESET;
			st_used_q <= 16'h0000;
			st_pend_q <= 16'h0000;
			reg_rdata_q <= 32'h0000_0000;
		end else begin
			tod_q <= tod_d;
			alm_prev_q <= alm_word;
			if (alm_word != alm_prev_q) begin
				stamp_q <= tod_q;
			end
			if (reg_wr && reg_addr == `SMR_REG_CTRL) begin
				ctrl_q <= reg_wdata[1:0];
			end
			if (st_valid) begin
				st_used_q[st_slot] <= 1'b1;
			end
			// Set wins over clear so a change during a send is not lost.
			st_pend_q <= (st_pend_q & ~pend_clr) | pend_set;
			reg_rdata_q <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					`SMR_REG_CTRL: reg_rdata_q <= {30'h0000_0000, ctrl_q};
					`SMR_REG_TIME: reg_rdata_q <= {8'h00, tod_q};
					`SMR_REG_STATUS: reg_rdata_q <= {15'h0000, alarm_active,
						alarm_avail, 1'b0, alm_pend_q, seq_pend_q, val_pend_q,
						busy_q, state_q};
					`SMR_REG_PEND: reg_rdata_q <= {16'h0000, st_pend_q};
					default: reg_rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Error reports hold one pending event per variant; a newer one overwrites.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			val_pend_q <= 1'b0;
			seq_pend_q <= 1'b0;
			alm_pend_q <= 1'b0;
			val_cmd_q <= 56'h00_0000_0000_0000;
			val_ext_q <= 24'h00_0000;
			seq_cmd_q <= 56'h00_0000_0000_0000;
			seq_ext_q <= 24'h00_0000;
		end else begin
			if (state_q == ST_IDLE) begin
				if (val_pend_q) begin
					val_pend_q <= 1'b0;
				end else if (seq_pend_q) begin
					seq_pend_q <= 1'b0;
				end else if (alm_pend_q) begin
					alm_pend_q <= 1'b0;
				end
			end
			if (msg_valid && msg_value_err) begin
				val_pend_q <= 1'b1;
				val_cmd_q <= msg_cmd;
				val_ext_q <= msg_ext;
			end
			if (msg_valid && msg_seq_err) begin
				seq_pend_q <= 1'b1;
				seq_cmd_q <= msg_cmd;
				seq_ext_q <= msg_ext;
			end
			if (alarm_req) begin
				alm_pend_q <= 1'b1;
			end
			if (alm_word != alm_prev_q && ctrl_q[`SMR_CTRL_ALM_EN]) begin
				alm_pend_q <= 1'b1;
			end
		end
	end

	// Message builder and character sender.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			rd_slot_q <= 4'h0;
			msg_q <= {26{8'h00}};
			remain_q <= 5'h00;
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					busy_q <= 1'b0;
					if (val_pend_q) begin
						msg_q <= {`SMR_CMD_REPORT, `SMR_CH_SP, `SMR_EXT_VALUE,
							`SMR_CH_SP, val_cmd_q, `SMR_CH_SP, val_ext_q,
							24'h00_0000};
						remain_q <= `SMR_LEN_REPORT;
						busy_q <= 1'b1;
						state_q <= ST_SEND;
					end else if (seq_pend_q) begin
						msg_q <= {`SMR_CMD_REPORT, `SMR_CH_SP, `SMR_EXT_SEQ,
							`SMR_CH_SP, seq_cmd_q, `SMR_CH_SP, seq_ext_q,
							24'h00_0000};
						remain_q <= `SMR_LEN_REPORT;
						busy_q <= 1'b1;
						state_q <= ST_SEND;
					end else if (alm_pend_q) begin
						msg_q <= {`SMR_CMD_ALARM, `SMR_CH_SP, `SMR_EXT_DEF,
							`SMR_CH_SP, alm_word, `SMR_CH_SP,
							hex_ch(stamp_q[23:20]), hex_ch(stamp_q[19:16]),
							`SMR_CH_COLON,
							hex_ch(stamp_q[15:12]), hex_ch(stamp_q[11:8]),
							`SMR_CH_COLON,
							hex_ch(stamp_q[7:4]), hex_ch(stamp_q[3:0])};
						remain_q <= `SMR_LEN_DEF;
						busy_q <= 1'b1;
						state_q <= ST_SEND;
					end else if (st_pend_q != 16'h0000) begin
						rd_slot_q <= lowest(st_pend_q);
						busy_q <= 1'b1;
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					msg_q <= {`SMR_CMD_STREAM, `SMR_CH_SP, `SMR_EXT_DEF,
						`SMR_CH_SP, hex_ch(entry[29:26]), hex_ch(entry[25:22]),
						hex_ch(entry[21:18]), `SMR_CH_SP,
						`SMR_CH_ZERO + {5'h00, entry[17:15]}, `SMR_CH_SP,
						err_ch(entry[14:13]), `SMR_CH_SP,
						up_dig[15:0],
						`SMR_CH_COLON, dec3(entry[7:0])};
					remain_q <= `SMR_LEN_DEF;
					state_q <= ST_SEND;
				end
				ST_SEND: begin
					if (!tx_valid_q || tx_ready) begin
						if (remain_q != 5'h00) begin
							tx_data_q <= msg_q[207:200];
							tx_valid_q <= 1'b1;
							tx_last_q <= (remain_q == 5'h01);
							msg_q <= {msg_q[199:0], 8'h00};
							remain_q <= remain_q - 5'h01;
						end else begin
							tx_valid_q <= 1'b0;
							tx_last_q <= 1'b0;
							busy_q <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire
